// >>> design/ims_defines.vh
// Purpose: constants shared by the two-wire master sequencer
// Assumes: included by bare name from the design file
// Notes: reset values and field positions of the software-facing bits
`ifndef IMS_DEFINES_VH
`define IMS_DEFINES_VH
`define IMS_RELOAD_W 8
`define IMS_RELOAD_MSB 7
`define IMS_BYTE_MSB 7
`define IMS_LAST_DATA_BIT 4'h7
`define IMS_ACK_BIT 4'h8
`define IMS_RST_BYTE 8'h00
`define IMS_RST_FLAG 1'b0
`define IMS_RST_LINE_RELEASED 1'b0
`define IMS_SYNC_IDLE 2'b11
`endif

// >>> design/ims_master_seq.v
// Purpose: master-side two-wire bus sequencer (start, repeated start,
//    byte transmit with ack capture, byte receive, ack sequence)
// Assumes: scl_i/sda_i are raw pin levels from another domain; all
//    software ports are synchronous to clk; *_set and *_clr are pulses
// Notes: pins are open drain, *_oe high pulls the line low
// Functional notes
// - start_go with both lines high loads the bit-rate counter from reload bits 7:0.
// - first start timeout drives data low if both lines high; sets start_detected.
// - after start, reload; next timeout clears start_go, suspends, data held low.
// - lines low at start, or clock low before data driven, is arbitration loss.
// - restart_go when idle pulls clock low, then loads counter, releases data.
// - on timeout with data high release clock; reload once high; data low next.
// - after restart data-low phase pull clock low, clear restart_go, no reload.
// - start detection is immediate; the event flag waits for the counter timeout.
// - restart_go requests are ignored while another bus event runs.
// - in restart, data low at clock rise or early clock low is arbitration loss.
// - buffer write sets buffer full, starts counter; bits clocked low then high.
// - after eighth falling clock clear buffer full and release data for the ack.
// - ninth clock response stored in ack_status_flag: low clears, high sets.
// - after ninth clock set event flag and stop with clock low until next write.
// - buffer write during transmit sets collision flag, buffer kept; software clears.
// - buffer write during reception sets collision flag and is discarded.
// - receive_go is accepted only when idle, otherwise disregarded.
// - in reception the clock toggles at each rollover and data shifts in.
// - after eighth received clock: clear go, copy byte, set flags, hold clock low.
// - reading the buffer after reception clears buffer full.
// - a byte arriving while buffer full is still set raises the overrun flag.
// - a released clock pauses the counter until the line reads high.
// - ack sequence: clock low, ack bit one period, clock high one period, idle.
`timescale 1ns/1ps
`include "ims_defines.vh"

module ims_master_seq #(
   parameter RELOAD_W = `IMS_RELOAD_W
) (
   input wire clk,
   input wire srst,
   input wire scl_i,
   input wire sda_i,
   output reg scl_o,
   output reg scl_oe,
   output reg sda_o,
   output reg sda_oe,
   input wire [RELOAD_W-1:0] bit_rate_reload,
   input wire start_set,
   input wire restart_set,
   input wire receive_set,
   input wire ack_seq_set,
   input wire ack_value_bit,
   input wire buf_wr,
   input wire [7:0] buf_wdata,
   input wire buf_rd,
   input wire write_collision_flag_clr,
   input wire ovf_clr,
   input wire event_clr,
   input wire arb_clr,
   input wire start_det_clr,
   output reg start_go,
   output reg restart_go,
   output reg receive_go,
   output reg ack_sequence_go,
   output reg [7:0] transfer_buffer,
   output reg buffer_full_flag,
   output reg write_collision_flag,
   output reg receive_overrun_flag,
   output reg serial_event_flag,
   output reg arbitration_lost_flag,
   output reg ack_status_flag,
   output reg start_detected
);

   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ST_A = 4'h1;
   localparam [3:0] S_ST_B = 4'h2;
   localparam [3:0] S_RS_A = 4'h3;
   localparam [3:0] S_RS_B = 4'h4;
   localparam [3:0] S_RS_C = 4'h5;
   localparam [3:0] S_RS_D = 4'h6;
   localparam [3:0] S_TX_L = 4'h7;
   localparam [3:0] S_TX_H = 4'h8;
   localparam [3:0] S_RX_L = 4'h9;
   localparam [3:0] S_RX_H = 4'ha;
   localparam [3:0] S_AK_L = 4'hb;
   localparam [3:0] S_AK_H = 4'hc;

   reg [1:0] scl_sync_q;
   reg [1:0] sda_sync_q;
   reg sda_prev_q;
   reg [3:0] state_q;
   reg [RELOAD_W-1:0] brg_q;
   reg hi_seen_q;
   reg [3:0] bit_q;
   reg [7:0] shift_register;

   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   wire tmo = (brg_q == {RELOAD_W{1'b0}});
   // start seen on the lines: data falls while clock is high
   wire start_seen = sda_prev_q & ~sda_s & scl_s;
   wire idle = (state_q == S_IDLE);
   wire [7:0] sh_next = {shift_register[6:0], sda_s};

   // set wins over clear on every flag below
   always @(posedge clk) begin
      if (srst) begin
         scl_sync_q <= `IMS_SYNC_IDLE;
         sda_sync_q <= `IMS_SYNC_IDLE;
         sda_prev_q <= 1'b1;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe <= `IMS_RST_LINE_RELEASED;
         sda_oe <= `IMS_RST_LINE_RELEASED;
         state_q <= S_IDLE;
         brg_q <= {RELOAD_W{1'b0}};
         hi_seen_q <= 1'b0;
         bit_q <= 4'h0;
         shift_register <= `IMS_RST_BYTE;
         transfer_buffer <= `IMS_RST_BYTE;
         start_go <= `IMS_RST_FLAG;
         restart_go <= `IMS_RST_FLAG;
         receive_go <= `IMS_RST_FLAG;
         ack_sequence_go <= `IMS_RST_FLAG;
         buffer_full_flag <= `IMS_RST_FLAG;
         write_collision_flag <= `IMS_RST_FLAG;
         receive_overrun_flag <= `IMS_RST_FLAG;
         serial_event_flag <= `IMS_RST_FLAG;
         arbitration_lost_flag <= `IMS_RST_FLAG;
         ack_status_flag <= `IMS_RST_FLAG;
         start_detected <= `IMS_RST_FLAG;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         sda_prev_q <= sda_s;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         if (!tmo) begin
            brg_q <= brg_q - {{(RELOAD_W-1){1'b0}}, 1'b1};
         end
         // software clears; any set later in this block overrides
         if (write_collision_flag_clr) begin
            write_collision_flag <= 1'b0;
         end
         if (ovf_clr) begin
            receive_overrun_flag <= 1'b0;
         end
         if (event_clr) begin
            serial_event_flag <= 1'b0;
         end
         if (arb_clr) begin
            arbitration_lost_flag <= 1'b0;
         end
         if (start_det_clr) begin
            start_detected <= 1'b0;
         end
         if (buf_rd) begin
            buffer_full_flag <= 1'b0;
         end
         if (start_seen) begin
            start_detected <= 1'b1;
         end
         // a write outside idle never lands in the buffer
         if (buf_wr && !idle) begin
            write_collision_flag <= 1'b1;
         end
         case (state_q)
            S_IDLE: begin
               hi_seen_q <= 1'b0;
               if (start_set) begin
                  if (scl_s && sda_s) begin
                     start_go <= 1'b1;
                     brg_q <= bit_rate_reload[`IMS_RELOAD_MSB:0];
                     state_q <= S_ST_A;
                  end else begin
                     arbitration_lost_flag <= 1'b1;
                  end
               end else if (restart_set) begin
                  restart_go <= 1'b1;
                  scl_oe <= 1'b1;
                  state_q <= S_RS_A;
               end else if (receive_set) begin
                  receive_go <= 1'b1;
                  sda_oe <= 1'b0;
                  scl_oe <= 1'b1;
                  bit_q <= 4'h0;
                  brg_q <= bit_rate_reload;
                  state_q <= S_RX_L;
               end else if (ack_seq_set) begin
                  ack_sequence_go <= 1'b1;
                  scl_oe <= 1'b1;
                  sda_oe <= ~ack_value_bit;
                  brg_q <= bit_rate_reload;
                  state_q <= S_AK_L;
               end else if (buf_wr) begin
                  transfer_buffer <= buf_wdata;
                  shift_register <= buf_wdata;
                  buffer_full_flag <= 1'b1;
                  scl_oe <= 1'b1;
                  sda_oe <= ~buf_wdata[`IMS_BYTE_MSB];
                  bit_q <= 4'h0;
                  brg_q <= bit_rate_reload;
                  state_q <= S_TX_L;
               end
            end
            S_ST_A: begin
               if (!scl_s) begin
                  arbitration_lost_flag <= 1'b1;
                  start_go <= 1'b0;
                  state_q <= S_IDLE;
               end else if (tmo) begin
                  if (sda_s) begin
                     sda_oe <= 1'b1;
                     start_detected <= 1'b1;
                     brg_q <= bit_rate_reload;
                     state_q <= S_ST_B;
                  end else begin
                     arbitration_lost_flag <= 1'b1;
                     start_go <= 1'b0;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_ST_B: begin
               if (tmo) begin
                  start_go <= 1'b0;
                  scl_oe <= 1'b1;
                  serial_event_flag <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_RS_A: begin
               if (!scl_s) begin
                  brg_q <= bit_rate_reload;
                  sda_oe <= 1'b0;
                  state_q <= S_RS_B;
               end
            end
            S_RS_B: begin
               if (tmo) begin
                  if (sda_s) begin
                     scl_oe <= 1'b0;
                     hi_seen_q <= 1'b0;
                     state_q <= S_RS_C;
                  end else begin
                     arbitration_lost_flag <= 1'b1;
                     restart_go <= 1'b0;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_RS_C: begin
               if (!hi_seen_q) begin
                  // counter waits until the clock really reads high
                  if (scl_s) begin
                     hi_seen_q <= 1'b1;
                     brg_q <= bit_rate_reload;
                     if (!sda_s) begin
                        arbitration_lost_flag <= 1'b1;
                        restart_go <= 1'b0;
                        state_q <= S_IDLE;
                     end
                  end else begin
                     brg_q <= bit_rate_reload;
                  end
               end else if (!scl_s) begin
                  arbitration_lost_flag <= 1'b1;
                  restart_go <= 1'b0;
                  state_q <= S_IDLE;
               end else if (tmo) begin
                  sda_oe <= 1'b1;
                  brg_q <= bit_rate_reload;
                  state_q <= S_RS_D;
               end
            end
            S_RS_D: begin
               if (tmo) begin
                  scl_oe <= 1'b1;
                  restart_go <= 1'b0;
                  serial_event_flag <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_TX_L, S_RX_L, S_AK_L: begin
               if (tmo) begin
                  scl_oe <= 1'b0;
                  hi_seen_q <= 1'b0;
                  state_q <= state_q + 4'h1;
               end
            end
            S_TX_H, S_RX_H, S_AK_H: begin
               if (!hi_seen_q) begin
                  brg_q <= bit_rate_reload;
                  if (scl_s) begin
                     hi_seen_q <= 1'b1;
                  end
               end else if (tmo) begin
                  scl_oe <= 1'b1;
                  hi_seen_q <= 1'b0;
                  brg_q <= bit_rate_reload;
                  bit_q <= bit_q + 4'h1;
                  if (state_q == S_TX_H) begin
                     if (bit_q == `IMS_ACK_BIT) begin
                        ack_status_flag <= sda_s;
                        serial_event_flag <= 1'b1;
                        state_q <= S_IDLE;
                     end else if (bit_q == `IMS_LAST_DATA_BIT) begin
                        buffer_full_flag <= 1'b0;
                        sda_oe <= 1'b0;
                        state_q <= S_TX_L;
                     end else begin
                        shift_register <= {shift_register[6:0], 1'b0};
                        sda_oe <= ~shift_register[`IMS_BYTE_MSB-1];
                        state_q <= S_TX_L;
                     end
                  end else if (state_q == S_RX_H) begin
                     shift_register <= sh_next;
                     if (bit_q == `IMS_LAST_DATA_BIT) begin
                        receive_go <= 1'b0;
                        transfer_buffer <= sh_next;
                        buffer_full_flag <= 1'b1;
                        serial_event_flag <= 1'b1;
                        if (buffer_full_flag && !buf_rd) begin
                           receive_overrun_flag <= 1'b1;
                        end
                        state_q <= S_IDLE;
                     end else begin
                        state_q <= S_RX_L;
                     end
                  end else begin
                     ack_sequence_go <= 1'b0;
                     serial_event_flag <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// >>> sim/ims_slave_model.sv
// Purpose: behavioural slave on the two-wire bus for the sequencer bench
// Assumes: both lines are open drain with pull-ups resolved by the bench
// Notes: counts clock falls after each start; acks writes, sends bytes on reads
`timescale 1ns/1ps
module ims_slave_model (
   input wire scl,
   input wire sda,
   input wire rd_mode,
   input wire ack_en,
   input wire [7:0] rd_byte,
   input wire stretch,
   output reg scl_pull,
   output wire sda_pull
);
   int bits = 0;
   int pos = 0;
   initial scl_pull = 1'b0;
   // data changes only well after a clock fall, never while the clock is high
   assign sda_pull = rd_mode ? (pos < 8 && !rd_byte[7 - pos]) : (pos == 8 && ack_en);
   always @(negedge sda) if (scl) bits = 0;
   always @(negedge scl) begin
      bits = bits + 1;
      #100;
      pos = (bits - 1) % 9;
   end
   // hold the clock low a while so the master must wait for it
   always @(negedge scl) if (stretch) begin
      scl_pull = 1'b1;
      #300;
      scl_pull = 1'b0;
   end
endmodule

// >>> sim/ims_master_seq_checker.sv
// Purpose: port-level assertions for the two-wire master sequencer
// Assumes: bound to ims_master_seq, one clock domain
// Notes: idle means no go bit high and no byte transfer being tracked
`timescale 1ns/1ps
module ims_master_seq_checker (
   input wire clk,
   input wire srst,
   input wire scl_oe,
   input wire sda_oe,
   input wire start_set,
   input wire restart_set,
   input wire receive_set,
   input wire ack_seq_set,
   input wire ack_value_bit,
   input wire buf_wr,
   input wire buf_rd,
   input wire start_go,
   input wire restart_go,
   input wire receive_go,
   input wire ack_sequence_go,
   input wire [7:0] transfer_buffer,
   input wire buffer_full_flag,
   input wire write_collision_flag,
   input wire receive_overrun_flag,
   input wire serial_event_flag,
   input wire arbitration_lost_flag,
   input wire start_detected
);
   wire busy = start_go || restart_go || receive_go || ack_sequence_go;
   // a byte transmit has no go bit of its own, so it is tracked here
   reg tx_q;
   reg ev_q;
   wire tx_done = serial_event_flag && !ev_q;
   wire idle_obs = !busy && (!tx_q || tx_done);
   always @(posedge clk) begin
      if (srst) begin
         tx_q <= 1'b0;
         ev_q <= 1'b0;
      end else begin
         ev_q <= serial_event_flag;
         if (buf_wr && idle_obs && !start_set && !restart_set && !receive_set
            && !ack_seq_set) begin
            tx_q <= 1'b1;
         end else if (tx_done) begin
            tx_q <= 1'b0;
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   AST_START_ACCEPT: assert property (
      start_set && idle_obs |=> start_go || arbitration_lost_flag)
      else $error("start not taken");
   AST_START_COND: assert property (
      $rose(sda_oe) && start_go |-> !scl_oe ##[0:4] start_detected) else $error("start bad");
   AST_START_END: assert property (
      $fell(start_go) |-> arbitration_lost_flag || (sda_oe && serial_event_flag))
      else $error("start end bad");
   AST_RESTART_IGN: assert property (
      restart_set && (start_go || receive_go || ack_sequence_go) |=> !restart_go)
      else $error("restart taken while busy");
   AST_TX_LOAD: assert property (
      $rose(buffer_full_flag) && $past(buf_wr) && !$fell(receive_go) |->
         scl_oe && sda_oe == !transfer_buffer[7])
      else $error("first bit bad");
   AST_WRITE_COLLISION_FLAG: assert property (
      buf_wr && busy |=> write_collision_flag && ($stable(transfer_buffer) || $fell(receive_go)))
      else $error("collision missed");
   AST_EVENT_HOLD: assert property (
      $rose(serial_event_flag) |-> scl_oe) else $error("clock not held low");
   AST_RX_DONE: assert property (
      $fell(receive_go) |-> buffer_full_flag && serial_event_flag) else $error("rx end bad");
   AST_OVERRUN: assert property (
      $fell(receive_go) && $past(buffer_full_flag) && !$past(buf_rd) |-> receive_overrun_flag)
      else $error("overrun missed");
   AST_ACK_DRIVE: assert property (
      $rose(ack_sequence_go) |-> scl_oe && sda_oe == !$past(ack_value_bit))
      else $error("ack drive bad");
endmodule
bind ims_master_seq ims_master_seq_checker u_chk (.clk, .srst, .scl_oe, .sda_oe, .start_set,
   .restart_set, .receive_set, .ack_seq_set, .ack_value_bit, .buf_wr, .buf_rd, .start_go,
   .restart_go, .receive_go,
   .ack_sequence_go, .transfer_buffer, .buffer_full_flag, .write_collision_flag,
   .receive_overrun_flag, .serial_event_flag, .arbitration_lost_flag, .start_detected);

// >>> sim/ims_master_seq_bench.sv
// Purpose: self-checking bench for the two-wire master sequencer
// Assumes: slave model on the far side, pull-ups on both lines
// Notes: reload 3 gives a clock-low phase of four clocks; the high phase counts four after the line reads high
`timescale 1ns/1ps
module ims_master_seq_bench;
   logic clk, srst, start_set, restart_set, receive_set, ack_seq_set, ack_value_bit;
   logic buf_wr, buf_rd, write_collision_flag_clr, ovf_clr, event_clr, arb_clr, start_det_clr;
   logic rd_mode, ack_en, stretch, jam;
   logic [7:0] buf_wdata, bit_rate_reload, rd_byte;
   logic [8:0] mon;
   logic [8:0] rows [4] = '{9'h1a4, 9'h15b, 9'h0ff, 9'h100};
   int miscompares = 0;
   int checked = 0;
   wire scl_oe, sda_oe, m_scl, m_sda, start_go, restart_go, receive_go, ack_sequence_go;
   wire buffer_full_flag, write_collision_flag, receive_overrun_flag, serial_event_flag;
   wire arbitration_lost_flag, ack_status_flag, start_detected;
   wire [7:0] transfer_buffer;
   wire scl = !(scl_oe | m_scl);
   wire sda = !(sda_oe | m_sda | jam);
   ims_master_seq dut (.clk, .srst, .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe, .sda_o(),
      .sda_oe, .bit_rate_reload, .start_set, .restart_set, .receive_set, .ack_seq_set,
      .ack_value_bit, .buf_wr, .buf_wdata, .buf_rd, .write_collision_flag_clr, .ovf_clr, .event_clr, .arb_clr,
      .start_det_clr, .start_go, .restart_go, .receive_go, .ack_sequence_go, .transfer_buffer,
      .buffer_full_flag, .write_collision_flag, .receive_overrun_flag, .serial_event_flag,
      .arbitration_lost_flag, .ack_status_flag, .start_detected);
   ims_slave_model peer (.scl, .sda, .rd_mode, .ack_en, .rd_byte, .stretch,
      .scl_pull(m_scl), .sda_pull(m_sda));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge scl) mon = {mon[7:0], sda};
   task automatic complete_run;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic req(input logic [4:0] s);
      @(negedge clk) {start_set, restart_set, receive_set, ack_seq_set, buf_wr} = s;
      @(negedge clk) {start_set, restart_set, receive_set, ack_seq_set, buf_wr} = 5'h00;
   endtask
   task automatic clr(input logic [5:0] s);
      @(negedge clk) {write_collision_flag_clr, ovf_clr, event_clr, arb_clr, start_det_clr, buf_rd} = s;
      @(negedge clk) {write_collision_flag_clr, ovf_clr, event_clr, arb_clr, start_det_clr, buf_rd} = 6'h00;
   endtask
   task automatic wait_ev;
      int n;
      n = 0;
      while (serial_event_flag !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) begin
         miscompares++;
         $display("Error at %0t: no event", $time);
         complete_run;
      end
   endtask
   initial begin
      {srst, start_set, restart_set, receive_set, ack_seq_set, buf_wr, buf_rd} = 7'h40;
      {write_collision_flag_clr, ovf_clr, event_clr, arb_clr, start_det_clr, ack_value_bit} = 6'h00;
      {rd_mode, ack_en, stretch, jam} = 4'h0;
      {buf_wdata, bit_rate_reload, rd_byte} = 24'h0003c3;
      mon = 9'h000;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      chk("reset", {buffer_full_flag, write_collision_flag, serial_event_flag, start_go,
         scl_oe, sda_oe, arbitration_lost_flag, transfer_buffer}, 15'h0000);
      $display("test reset done");
      repeat (3) @(negedge clk);
      req(5'h10);
      chk("start go", start_go, 1'b1);
      buf_wdata = 8'h3c;
      req(5'h01);
      req(5'h08);
      req(5'h04);
      chk("write_collision_flag", {write_collision_flag, transfer_buffer}, 9'h100);
      chk("ignored", {restart_go, receive_go}, 2'b00);
      clr(6'h20);
      wait_ev;
      chk("start end", {start_go, start_detected, sda_oe, scl_oe}, 4'h7);
      clr(6'h08);
      $display("test start done");
      for (int i = 0; i < 4; i++) begin
         ack_en = rows[i][8];
         buf_wdata = rows[i][7:0];
         req(5'h01);
         chk("tx load", {buffer_full_flag, transfer_buffer}, {1'b1, rows[i][7:0]});
         wait_ev;
         chk("tx wire", mon, {rows[i][7:0], !rows[i][8]});
         chk("ack_status_flag", ack_status_flag, !rows[i][8]);
         chk("tx idle", {buffer_full_flag, scl_oe}, 2'b01);
         clr(6'h08);
      end
      $display("test transmit done");
      clr(6'h02);
      req(5'h08);
      chk("restart go", restart_go, 1'b1);
      wait_ev;
      chk("restart end", {restart_go, start_detected, sda_oe, scl_oe}, 4'h7);
      {ack_en, buf_wdata} = 9'h1a5;
      clr(6'h08);
      req(5'h01);
      wait_ev;
      chk("addr rd", mon, {8'ha5, 1'b0});
      clr(6'h08);
      $display("test restart done");
      {rd_mode, stretch} = 2'b11;
      req(5'h04);
      chk("rx go", receive_go, 1'b1);
      buf_wdata = 8'h77;
      req(5'h01);
      chk("rx write_collision_flag", {write_collision_flag, transfer_buffer}, 9'h1a5);
      wait_ev;
      chk("rx byte", {receive_go, buffer_full_flag, receive_overrun_flag, transfer_buffer},
         {3'b010, 8'hc3});
      clr(6'h28);
      stretch = 1'b0;
      req(5'h02);
      chk("ack go", ack_sequence_go, 1'b1);
      wait_ev;
      chk("ack wire", {mon[0], ack_sequence_go}, 2'b00);
      clr(6'h08);
      rd_byte = 8'h81;
      req(5'h04);
      wait_ev;
      chk("overrun", {receive_overrun_flag, buffer_full_flag, transfer_buffer}, 10'h381);
      clr(6'h01);
      chk("read", buffer_full_flag, 1'b0);
      clr(6'h18);
      ack_value_bit = 1'b1;
      req(5'h02);
      wait_ev;
      chk("nack wire", {mon[0], ack_sequence_go, sda_oe}, 3'b100);
      $display("test receive done");
      jam = 1'b1;
      repeat (4) @(negedge clk);
      req(5'h10);
      chk("arb", {arbitration_lost_flag, start_go}, 2'b10);
      clr(6'h04);
      req(5'h08);
      repeat (8) @(negedge clk);
      chk("rs arb", {arbitration_lost_flag, restart_go}, 2'b10);
      jam = 1'b0;
      $display("test arbitration done");
      buf_wdata = 8'h96;
      req(5'h01);
      repeat (6) @(negedge clk);
      srst = 1'b1;
      @(negedge clk);
      srst = 1'b0;
      chk("mid reset", {buffer_full_flag, scl_oe, sda_oe, arbitration_lost_flag}, 4'h0);
      $display("test mid reset done");
      complete_run;
   end
endmodule
